// [hdl/adcreg_cfg.svh]
// Register map, field positions and reset values of the converter registers
`ifndef ADCREG_CFG_SVH
`define ADCREG_CFG_SVH

// Bus widths
`define ADCREG_ADDR_W        12
`define ADCREG_DATA_W        8
`define ADCREG_RES_W         10

// Register offsets
`define ADCREG_OFF_CTRL      12'hF70
`define ADCREG_OFF_RES_HI    12'hF72
`define ADCREG_OFF_RES_LO    12'hF73
`define ADCREG_OFF_IRQ_STAT  12'hF7C
`define ADCREG_OFF_IRQ_MASK  12'hF7D

// Control register fields
`define ADCREG_CTRL_START    7
`define ADCREG_CTRL_RSVD6    6
`define ADCREG_CTRL_REFON    5
`define ADCREG_CTRL_PWRON    4
`define ADCREG_CTRL_RSVD3    3
`define ADCREG_CTRL_CH_HI    2
`define ADCREG_CTRL_CH_LO    0

// Low result register field
`define ADCREG_LO_HI         7
`define ADCREG_LO_LO         6

// Interrupt status and mask fields
`define ADCREG_IRQ_DONE      0
`define ADCREG_IRQ_W         1

// Reset values
`define ADCREG_CTRL_RST      8'h00
`define ADCREG_RES_RST       10'h000
`define ADCREG_DATA_RST      8'h00
`define ADCREG_CH_RST        3'h0
`define ADCREG_IRQ_RST       1'h0

`endif

// [hdl/adcreg_pkg.sv]
// Types shared by the converter register block
package adcreg_pkg;

  typedef enum logic [0:0] {
    ADCREG_IDLE = 1'b0,
    ADCREG_BUSY = 1'b1
  } adcreg_state_t;

  typedef logic [2:0] adcreg_chan_t;

endpackage : adcreg_pkg

// [hdl/adcreg_top.sv]
// Converter control and result registers with done interrupt
//
// Overview of operation
// [R01] Writing one to the start bit begins a new conversion; here only from idle, and only if the same write leaves power on.
// [R02] Writing zero to the start bit changes nothing, never aborts.
// [R03] Start bit reads one while a conversion is running.
// [R04] Start bit reads zero when the converter is idle.
// [R05] Reference-enable set switches internal reference on, onto its pin.
// [R06] Reference-enable clear selects the external reference.
// [R07] Enable bit zero powers converter down, one makes it operational.
// [R08] Three-bit channel field code n selects analog input n.
// [R09] Software writes zero to reserved control bits six and three.
// [R10] Result registers hold the last result until the next one completes.
// [R11] Ten-bit result: eight upper bits high byte, two lower in bits 7:6.
// [R12] Reading the high byte latches the matching two low bits.
// [R13] Result contents after reset are undefined to software.
// [R14] Reset clears the whole control register to zero.
// [R15] Busy clears in the cycle the result is written.
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`include "adcreg_cfg.svh"

module adcreg_top (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          nrst,
  // Register port
  input  wire logic [`ADCREG_ADDR_W-1:0]     reg_addr,
  input  wire logic [`ADCREG_DATA_W-1:0]     reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [`ADCREG_DATA_W-1:0]     reg_rdata,
  // Converter core
  output logic                               conv_start,
  output adcreg_pkg::adcreg_chan_t           channel_select,
  output logic                               internal_ref_on,
  output logic                               converter_power_on,
  input  wire logic                          conv_done,
  input  wire logic [`ADCREG_RES_W-1:0]      conv_result,
  // Interrupt
  output logic                               irq
);
  import adcreg_pkg::*;

  adcreg_state_t                state_reg;
  adcreg_state_t                state_next;
  logic [`ADCREG_RES_W-1:0]     result_reg;
  logic [1:0]                   lower_latch_reg;
  logic                         done_stat_reg;
  logic                         done_stat_next;
  logic                         done_mask_reg;
  logic                         wr_ctrl;
  logic                         wr_stat;
  logic                         wr_mask;
  logic                         rd_hi;
  logic                         power_next;
  logic                         start_req;
  logic                         finish;
  logic [`ADCREG_DATA_W-1:0]    rdata_next;

  assign wr_ctrl = reg_wr && (reg_addr == `ADCREG_OFF_CTRL);
  assign wr_stat = reg_wr && (reg_addr == `ADCREG_OFF_IRQ_STAT);
  assign wr_mask = reg_wr && (reg_addr == `ADCREG_OFF_IRQ_MASK);
  assign rd_hi   = reg_rd && (reg_addr == `ADCREG_OFF_RES_HI);

  // Power state in force after this cycle's write
  assign power_next = wr_ctrl ? reg_wdata[`ADCREG_CTRL_PWRON]
                              : converter_power_on;

  // Start only from idle and powered; a powered-down core would never finish
  assign start_req = wr_ctrl && reg_wdata[`ADCREG_CTRL_START] // see [R01]
                     && power_next && (state_reg == ADCREG_IDLE);
  // A written zero never reaches the state machine, see [R02]

  assign finish = conv_done && (state_reg == ADCREG_BUSY);

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ADCREG_IDLE:
      begin
        if (start_req)
          state_next = ADCREG_BUSY; // see [R01]
      end
      ADCREG_BUSY:
      begin
        // Power-down abandons the conversion so busy cannot hang
        if (finish || !power_next)
          state_next = ADCREG_IDLE; // see [R15]
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      state_reg <= ADCREG_IDLE; // see [R14]
    else
      state_reg <= state_next;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      conv_start <= 1'b0;
    else
      conv_start <= start_req; // see [R01]
  end

  // Control fields; reserved bits are not stored, see [R09]
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      channel_select     <= `ADCREG_CH_RST; // see [R14]
      internal_ref_on    <= 1'b0;
      converter_power_on <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      // see [R08]
      channel_select     <= reg_wdata[`ADCREG_CTRL_CH_HI:`ADCREG_CTRL_CH_LO];
      internal_ref_on    <= reg_wdata[`ADCREG_CTRL_REFON]; // see [R05] [R06]
      converter_power_on <= reg_wdata[`ADCREG_CTRL_PWRON]; // see [R07]
    end
  end

  // Reset value is a convenience only; software must wait for a result
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      result_reg <= `ADCREG_RES_RST; // see [R13]
    else if (finish)
      result_reg <= conv_result; // see [R10] [R15]
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      lower_latch_reg <= 2'h0;
    else if (rd_hi)
      lower_latch_reg <= result_reg[1:0]; // see [R12]
  end

  // Set wins over a same-cycle write-one-to-clear
  assign done_stat_next = finish ||
    (done_stat_reg && !(wr_stat && reg_wdata[`ADCREG_IRQ_DONE]));

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      done_stat_reg <= `ADCREG_IRQ_RST;
    else
      done_stat_reg <= done_stat_next;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      done_mask_reg <= `ADCREG_IRQ_RST;
    else if (wr_mask)
      done_mask_reg <= reg_wdata[`ADCREG_IRQ_DONE];
  end

  // Registered so the pin comes from a flop; one cycle behind status
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      irq <= 1'b0;
    else
      irq <= done_stat_reg && done_mask_reg;
  end

  always_comb
  begin
    rdata_next = `ADCREG_DATA_RST;
    if (reg_rd)
    begin
      unique case (reg_addr)
        `ADCREG_OFF_CTRL:
        begin
          // see [R03] [R04]
          rdata_next[`ADCREG_CTRL_START] = (state_reg == ADCREG_BUSY);
          rdata_next[`ADCREG_CTRL_REFON] = internal_ref_on;
          rdata_next[`ADCREG_CTRL_PWRON] = converter_power_on;
          rdata_next[`ADCREG_CTRL_CH_HI:`ADCREG_CTRL_CH_LO] = channel_select;
        end
        `ADCREG_OFF_RES_HI:
          rdata_next = result_reg[9:2]; // see [R11]
        `ADCREG_OFF_RES_LO:
          // see [R11]
          rdata_next[`ADCREG_LO_HI:`ADCREG_LO_LO] = lower_latch_reg;
        `ADCREG_OFF_IRQ_STAT:
          rdata_next[`ADCREG_IRQ_DONE] = done_stat_reg;
        `ADCREG_OFF_IRQ_MASK:
          rdata_next[`ADCREG_IRQ_DONE] = done_mask_reg;
        default:
          rdata_next = `ADCREG_DATA_RST;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      reg_rdata <= `ADCREG_DATA_RST;
    else
      reg_rdata <= rdata_next;
  end

endmodule : adcreg_top

// [verification/adcreg_asserts.sv]
// Port assertions for the converter register block
`timescale 1ns/1ps
module adcreg_asserts (
  input wire logic        clk, nrst, reg_wr, reg_rd,
  input wire logic        conv_start, conv_done,
  input wire logic        internal_ref_on, converter_power_on,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0]  reg_wdata, reg_rdata,
  input wire logic [9:0]  conv_result,
  input wire adcreg_pkg::adcreg_chan_t channel_select
);
  import adcreg_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire ctl_wr = reg_wr && reg_addr == 12'hF70;
  // Done arriving in the start cycle ends the conversion at once
  sequence fin_s; conv_start && conv_done && !reg_wr; endsequence
  sequence hi_s; reg_rd && reg_addr == 12'hF72; endsequence
  sequence lo_s; reg_rd && reg_addr == 12'hF73; endsequence
  start_pulse_a: assert property (conv_start |=> !conv_start)
    else $error("start pulse too long");
  start_cause_a: assert property (conv_start |->
    $past(ctl_wr && reg_wdata[7] && reg_wdata[4])) else $error("stray start");
  chan_set_a: assert property (ctl_wr |=>
    channel_select == $past(reg_wdata[2:0])) else $error("bad channel");
  ref_set_a: assert property (ctl_wr |=>
    internal_ref_on == $past(reg_wdata[5])) else $error("bad reference");
  power_set_a: assert property (ctl_wr |=>
    converter_power_on == $past(reg_wdata[4])) else $error("bad power");
  busy_read_a: assert property (conv_start && reg_rd &&
    reg_addr == 12'hF70 |=> reg_rdata[7]) else $error("busy not shown");
  res_high_a: assert property (fin_s ##2 hi_s |=>
    reg_rdata == $past(conv_result[9:2], 3)) else $error("bad high byte");
  res_low_a: assert property (fin_s ##2 hi_s ##2 lo_s |=>
    reg_rdata == {$past(conv_result[1:0], 5), 6'h00}) else $error("bad low");
endmodule : adcreg_asserts

// [verification/adcreg_bench.sv]
// Self-checking bench for the converter register block
`timescale 1ns/1ps
module adcreg_bench;
  import adcreg_pkg::*;
  logic         conv_start, irq, internal_ref_on, converter_power_on;
  logic         clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic         conv_done = 1'b0;
  logic [11:0]  reg_addr = 12'h000;
  logic [7:0]   reg_wdata = 8'h00, reg_rdata, c;
  logic [9:0]   conv_result = 10'h000, r1, r2;
  logic [31:0]  rn;
  // Model of finished conversions, newest last
  logic [9:0]   conv_q[$];
  adcreg_chan_t channel_select;
  int           err_total = 0, compares = 0, seed = 55346;
  adcreg_top dut (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .conv_start, .channel_select, .internal_ref_on,
    .converter_power_on, .conv_done, .conv_result, .irq);
  initial forever #5 clk = ~clk;
  task chk(input string n, input logic [9:0] s, e);
    compares++;
    err_total += int'(s !== e);
    if (s !== e)
      $display("wrong value %s exp %h seen %h", n, e, s);
  endtask : chk
  // Strobe tasks leave one idle cycle so no strobe is driven twice
  task wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [11:0] a, input string n, input logic [9:0] e);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(n, {2'b00, reg_rdata}, e);
  endtask : rd
  // Delay zero answers in the start cycle; else zero-start writes first
  task conv(input int d, input logic [9:0] r, input logic [7:0] cw);
    wr(12'hF70, cw);
    reg_rd      <= 1'b1;
    conv_done   <= d == 0;
    conv_result <= r;
    conv_q.push_back(r);
    #1 chk("start", conv_start, 1);
    @(posedge clk);
    reg_rd    <= 1'b0;
    conv_done <= 1'b0;
    #1 chk("busy", reg_rdata[7], 1);
    if (d > 0)
    begin
      repeat (d) wr(12'hF70, cw & 8'h7F);
      conv_done <= 1'b1;
      @(posedge clk);
      conv_done <= 1'b0;
    end
  endtask : conv
  task finish_test;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  initial
  begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    rd(12'hF70, "ctrl", 0);
    rd(12'hF71, "gap", 0);
    wr(12'hF70, 8'h80);
    #1 chk("nopwr", conv_start, 0);
    for (int i = 0; i < 8; i++)
    begin
      rn = $random(seed);
      c  = 8'h10 | (rn[7:0] & 8'h20) | 8'(i);
      wr(12'hF70, c);
      #1 chk("chan", channel_select, i);
      chk("ref", internal_ref_on, c[5]);
      rd(12'hF70, "ctrl", c);
    end
    rn = $random(seed);
    r1 = rn[9:0];
    r2 = rn[25:16];
    conv(0, r1, 8'h95);
    rd(12'hF72, "high", conv_q[$][9:2]);
    rd(12'hF73, "low", {r1[1:0], 6'h00});
    rd(12'hF70, "idle", 8'h15);
    chk("irq", irq, 0);
    wr(12'hF7D, 8'h01);
    rd(12'hF7C, "stat", 1);
    chk("irq", irq, 1);
    wr(12'hF7C, 8'h01);
    rd(12'hF7C, "stat", 0);
    chk("irq", irq, 0);
    rd(12'hF72, "keep", r1[9:2]);
    conv(3, r2, 8'hB2);
    rd(12'hF73, "latch", {r1[1:0], 6'h00});
    rd(12'hF72, "high", conv_q[$][9:2]);
    rd(12'hF73, "low", {r2[1:0], 6'h00});
    chk("irq", irq, 1);
    // Second start while busy is refused; power-down then abandons it
    wr(12'hF70, 8'h90);
    wr(12'hF70, 8'h97);
    #1 chk("rebusy", conv_start, 0);
    wr(12'hF70, 8'h00);
    rd(12'hF70, "abort", 0);
    finish_test();
  end
endmodule : adcreg_bench
bind adcreg_top adcreg_asserts chk_i (.clk, .nrst, .reg_wr, .reg_rd,
  .conv_start, .conv_done, .internal_ref_on, .converter_power_on,
  .reg_addr, .reg_wdata, .reg_rdata, .conv_result, .channel_select);
